//--- logic/idau_top.sv
// Indirect data addressing unit with Avalon-MM register access

// Behaviour
// - A virtual operand access reads or writes data memory at the pointer address and stores nothing itself.
// - The offset operand addresses memory at the pointer plus the accumulator.
// - The pre-increment operand steps the pointer first and uses the stepped value as address.
// - Each pointer high part holds four bits and clears to zero on every reset.
// - Pointer low bytes and the accumulator are undefined at power-up and kept over other resets.
// - The external reset pin and a watchdog timeout are treated as non-power-up resets.
module idau_top (
    input  wire logic                          CORE_CLK_IN,
    input  wire logic                          RST_IN,
    input  wire logic                          EXTERNAL_RESET_PIN_N_IN,
    input  wire logic                          WATCHDOG_RESET_IN,
    input  wire logic [idau_pkg::ADDR_W-1:0]   AVS_ADDRESS_IN,
    input  wire logic                          AVS_READ_IN,
    input  wire logic                          AVS_WRITE_IN,
    input  wire logic [idau_pkg::DATA_W-1:0]   AVS_WRITEDATA_IN,
    input  wire logic [idau_pkg::BE_W-1:0]     AVS_BYTEENABLE_IN,
    output logic      [idau_pkg::DATA_W-1:0]   AVS_READDATA_OUT,
    output logic                               AVS_WAITREQUEST_OUT
);
    import idau_pkg::*;

    // =====================================================================
    // Declarations
    idau_state_t       state_reg;
    idau_state_t       state_next;
    logic [DATA_W-1:0] readdata_reg;
    logic [BYTE_W-1:0] accum_reg;
    logic [NIB_W-1:0]  bank_reg;
    logic              pin_meta_reg;
    logic              pin_sync_reg;
    logic [PTR_W-1:0]  ptr_val [NUM_PTRS];

    // =====================================================================
    // Other-reset sources
    // Pin is asynchronous to the core; watchdog comes from core logic
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
        end else begin
            pin_meta_reg <= EXTERNAL_RESET_PIN_N_IN;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire other_rst = !pin_sync_reg || WATCHDOG_RESET_IN;

    // =====================================================================
    // Address decode
    wire [1:0] grp  = AVS_ADDRESS_IN[GRP_MSB:GRP_LSB];
    wire [2:0] slot = AVS_ADDRESS_IN[SLOT_MSB:SLOT_LSB];

    wire aligned    = AVS_ADDRESS_IN[LANE_MSB:0] == LANE_ZERO
                      && !AVS_ADDRESS_IN[SPARE_BIT];
    wire ptr_grp    = aligned && grp != GRP_SHARED;
    wire shared_grp = aligned && grp == GRP_SHARED;
    wire [1:0] ptr_idx = ptr_grp ? grp : 2'h0;

    wire is_mem     = ptr_grp && slot <= SLOT_OFFSET;
    wire hit_high   = ptr_grp && slot == SLOT_PTR_HIGH;
    wire hit_low    = ptr_grp && slot == SLOT_PTR_LOW;
    wire hit_accum  = shared_grp && slot == SLOT_ACCUM;
    wire hit_bank   = shared_grp && slot == SLOT_BANK;

    wire op_post_inc = ptr_grp && slot == SLOT_POST_INC;
    wire op_post_dec = ptr_grp && slot == SLOT_POST_DEC;
    wire op_pre_inc  = ptr_grp && slot == SLOT_PRE_INC;
    wire op_offset   = ptr_grp && slot == SLOT_OFFSET;

    // =====================================================================
    // Effective data-memory address
    wire [PTR_W-1:0] sel_ptr    = ptr_val[ptr_idx];
    wire [PTR_W-1:0] accum_wide = {OFFSET_EXTEND, accum_reg};
    // Offset treated as unsigned; no wrap check beyond 12 bits
    wire [PTR_W-1:0] mem_addr   =
        op_pre_inc ? sel_ptr + PTR_STEP :
        op_offset  ? sel_ptr + accum_wide :
        sel_ptr;

    // =====================================================================
    // Bus sequencer
    wire req    = AVS_READ_IN || AVS_WRITE_IN;
    wire commit = state_reg == ST_DONE && req;
    wire wr_ok  = commit && AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
    wire [BYTE_W-1:0] wbyte = AVS_WRITEDATA_IN[BYTE_W-1:0];

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (req) begin
                    state_next = ST_FETCH;
                end
            end
            ST_FETCH: begin
                state_next = ST_DONE;
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Only the DONE cycle releases the master
    assign AVS_WAITREQUEST_OUT = state_reg != ST_DONE;

    // =====================================================================
    // Data memory
    logic [BYTE_W-1:0] ram_rdata;
    wire               ram_we = wr_ok && is_mem;

    idau_data_ram u_ram (
        .clk_in    (CORE_CLK_IN),
        .we_in     (ram_we),
        .addr_in   (mem_addr),
        .wdata_in  (wbyte),
        .rdata_out (ram_rdata)
    );

    // =====================================================================
    // Pointers
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PTRS; gi++) begin : g_ptr
            wire mine = commit && ptr_idx == 2'(gi);
            idau_pointer u_ptr (
                .clk_in        (CORE_CLK_IN),
                .rst_in        (RST_IN),
                .soft_clear_in (other_rst),
                .load_high_in  (wr_ok && mine && hit_high),
                .load_low_in   (wr_ok && mine && hit_low),
                .wdata_in      (wbyte),
                .inc_in        (mine && (op_post_inc || op_pre_inc)),
                .dec_in        (mine && op_post_dec),
                .ptr_out       (ptr_val[gi])
            );
        end
    endgenerate

    // =====================================================================
    // Accumulator and bank selector
    // Accumulator is data, not control: left without reset
    always_ff @(posedge CORE_CLK_IN) begin
        if (wr_ok && hit_accum) begin
            accum_reg <= wbyte;
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            bank_reg <= BANK_RESET;
        end else if (other_rst) begin
            bank_reg <= BANK_RESET;
        end else if (wr_ok && hit_bank) begin
            bank_reg <= wbyte[NIB_W-1:0];
        end
    end

    // =====================================================================
    // Read data
    wire [BYTE_W-1:0] reg_byte =
        hit_high  ? {OFFSET_EXTEND, sel_ptr[PTR_W-1:BYTE_W]} :
        hit_low   ? sel_ptr[BYTE_W-1:0] :
        hit_accum ? accum_reg :
        hit_bank  ? {OFFSET_EXTEND, bank_reg} :
        READ_ZERO[BYTE_W-1:0];
    wire [BYTE_W-1:0] rd_byte = is_mem ? ram_rdata : reg_byte;

    // Captured one cycle before release, so data stand at the done edge
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            readdata_reg <= READ_ZERO;
        end else if (state_reg == ST_FETCH) begin
            readdata_reg <= {READ_ZERO[DATA_W-1:BYTE_W], rd_byte};
        end
    end

    assign AVS_READDATA_OUT = readdata_reg;

    // =====================================================================
    // Checks
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    wire calm = !other_rst;

    plain_keeps_a: assert property (
        commit && ptr_grp && slot == SLOT_INDIRECT && calm
        |=> ptr_val[$past(ptr_idx)] == $past(sel_ptr))
        else $error("plain operand changed its pointer");

    post_inc_a: assert property (
        commit && op_post_inc && calm
        |=> ptr_val[$past(ptr_idx)] == $past(sel_ptr) + PTR_STEP)
        else $error("post-increment did not step pointer");

    post_dec_a: assert property (
        commit && op_post_dec && calm
        |=> ptr_val[$past(ptr_idx)] == $past(sel_ptr) - PTR_STEP)
        else $error("post-decrement did not step pointer");

    pre_inc_addr_a: assert property (
        commit && op_pre_inc && calm
        |=> ptr_val[$past(ptr_idx)] == $past(mem_addr))
        else $error("pre-increment address differs from new pointer");

    offset_addr_a: assert property (
        commit && op_offset && wr_ok
        |=> u_ram.mem[$past(sel_ptr + accum_wide)] == $past(wbyte))
        else $error("offset write missed pointer plus accumulator");

    mem_write_a: assert property (
        ram_we |=> ##1 u_ram.mem[$past(mem_addr, 2)]
                       == $past(wbyte, 2))
        else $error("operand write missed data memory");

    high_clear_a: assert property (
        other_rst |=> ptr_val[0][PTR_W-1:BYTE_W] == HIGH_RESET
                   && ptr_val[1][PTR_W-1:BYTE_W] == HIGH_RESET
                   && ptr_val[2][PTR_W-1:BYTE_W] == HIGH_RESET
                   && bank_reg == BANK_RESET)
        else $error("other reset left a high part set");

    low_kept_a: assert property (
        other_rst && !commit
        |=> $stable(ptr_val[0][BYTE_W-1:0])
            && $stable(ptr_val[1][BYTE_W-1:0])
            && $stable(ptr_val[2][BYTE_W-1:0])
            && $stable(accum_reg))
        else $error("other reset disturbed a low byte");

    wait_bound_a: assert property (
        state_reg == ST_IDLE && req
        |=> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
        else $error("bus answer not two cycles after request");

    wait_single_a: assert property (
        !AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
        else $error("waitrequest low for more than one cycle");

    // Reads checked against the array itself, not the read mux
    plain_read_a: assert property (
        state_reg == ST_DONE && AVS_READ_IN && is_mem
        && !op_pre_inc && !op_offset
        |-> AVS_READDATA_OUT[BYTE_W-1:0] == u_ram.mem[sel_ptr])
        else $error("operand read not at current pointer");

    pre_inc_read_a: assert property (
        state_reg == ST_DONE && AVS_READ_IN && op_pre_inc
        |-> AVS_READDATA_OUT[BYTE_W-1:0] == u_ram.mem[sel_ptr + PTR_STEP])
        else $error("pre-increment read not at stepped pointer");

    offset_read_a: assert property (
        state_reg == ST_DONE && AVS_READ_IN && op_offset
        |-> AVS_READDATA_OUT[BYTE_W-1:0]
            == u_ram.mem[sel_ptr + accum_wide])
        else $error("offset read not at pointer plus accumulator");

    offset_keeps_a: assert property (
        commit && op_offset && calm
        |=> ptr_val[$past(ptr_idx)] == $past(sel_ptr))
        else $error("offset operand changed its pointer");

    high_upper_a: assert property (
        state_reg == ST_DONE && AVS_READ_IN && hit_high
        |-> AVS_READDATA_OUT[DATA_W-1:NIB_W]
            == READ_ZERO[DATA_W-1:NIB_W])
        else $error("pointer high part read above four bits");

    high_write_a: assert property (
        wr_ok && hit_high && calm
        |=> ptr_val[$past(ptr_idx)][PTR_W-1:BYTE_W]
            == $past(wbyte[NIB_W-1:0]))
        else $error("pointer high part write lost");

    low_write_a: assert property (
        wr_ok && hit_low && calm
        |=> ptr_val[$past(ptr_idx)][BYTE_W-1:0] == $past(wbyte))
        else $error("pointer low byte write lost");

    pin_clear_a: assert property (
        !EXTERNAL_RESET_PIN_N_IN
        |-> ##3 (ptr_val[1][PTR_W-1:BYTE_W] == HIGH_RESET
                 && bank_reg == BANK_RESET))
        else $error("reset pin did not clear high parts");

    wdt_clear_a: assert property (
        WATCHDOG_RESET_IN
        |=> ptr_val[2][PTR_W-1:BYTE_W] == HIGH_RESET)
        else $error("watchdog did not clear a high part");

endmodule : idau_top

//--- inc/idau_pkg.sv
// Shared constants and types of the indirect data addressing unit
package idau_pkg;

    // =====================================================================
    // Widths
    localparam int BYTE_W    = 8;
    localparam int NIB_W     = 4;
    localparam int PTR_W     = 12;
    localparam int DATA_W    = 32;
    localparam int ADDR_W    = 8;
    localparam int BE_W      = 4;
    localparam int NUM_PTRS  = 3;
    localparam int MEM_DEPTH = 4096;

    // =====================================================================
    // Register map: byte address = group * 0x20 + slot * 4
    localparam int GRP_LSB   = 5;
    localparam int GRP_MSB   = 6;
    localparam int SLOT_LSB  = 2;
    localparam int SLOT_MSB  = 4;
    localparam int SPARE_BIT = 7;
    localparam int LANE_MSB  = 1;

    localparam logic [1:0] GRP_SHARED = 2'h3;
    localparam logic [1:0] LANE_ZERO  = 2'h0;

    // Slots inside a pointer group
    localparam logic [2:0] SLOT_INDIRECT = 3'h0;
    localparam logic [2:0] SLOT_POST_INC = 3'h1;
    localparam logic [2:0] SLOT_POST_DEC = 3'h2;
    localparam logic [2:0] SLOT_PRE_INC  = 3'h3;
    localparam logic [2:0] SLOT_OFFSET   = 3'h4;
    localparam logic [2:0] SLOT_PTR_HIGH = 3'h5;
    localparam logic [2:0] SLOT_PTR_LOW  = 3'h6;

    // Slots inside the shared group
    localparam logic [2:0] SLOT_ACCUM    = 3'h0;
    localparam logic [2:0] SLOT_BANK     = 3'h1;

    // =====================================================================
    // Reset values
    localparam logic [NIB_W-1:0]  HIGH_RESET    = 4'h0;
    localparam logic [NIB_W-1:0]  BANK_RESET    = 4'h0;
    localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0;
    localparam logic [PTR_W-1:0]  PTR_STEP      = 12'h001;
    localparam logic [NIB_W-1:0]  OFFSET_EXTEND = 4'h0;

    // =====================================================================
    // Bus sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_DONE  = 3'b100
    } idau_state_t;

endpackage : idau_pkg

//--- logic/idau_data_ram.sv
// Data memory reached through the file-select pointers
module idau_data_ram (
    input  wire logic                         clk_in,
    input  wire logic                         we_in,
    input  wire logic [idau_pkg::PTR_W-1:0]   addr_in,
    input  wire logic [idau_pkg::BYTE_W-1:0]  wdata_in,
    output logic      [idau_pkg::BYTE_W-1:0]  rdata_out
);
    import idau_pkg::*;

    // Contents undefined at power-up, like any static RAM
    logic [BYTE_W-1:0] mem [MEM_DEPTH];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end

endmodule : idau_data_ram

//--- logic/idau_pointer.sv
// One 12-bit file-select pointer: 4-bit high part and 8-bit low byte
module idau_pointer (
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    input  wire logic                         soft_clear_in,
    input  wire logic                         load_high_in,
    input  wire logic                         load_low_in,
    input  wire logic [idau_pkg::BYTE_W-1:0]  wdata_in,
    input  wire logic                         inc_in,
    input  wire logic                         dec_in,
    output logic      [idau_pkg::PTR_W-1:0]   ptr_out
);
    import idau_pkg::*;

    logic [NIB_W-1:0]  high_reg;
    logic [NIB_W-1:0]  high_next;
    logic [BYTE_W-1:0] low_reg;
    logic [BYTE_W-1:0] low_next;
    logic [PTR_W-1:0]  stepped;

    assign ptr_out   = {high_reg, low_reg};
    // Carry and borrow ripple into the high part
    assign stepped   = inc_in ? ptr_out + PTR_STEP :
                       dec_in ? ptr_out - PTR_STEP : ptr_out;
    assign high_next = soft_clear_in ? HIGH_RESET :
                       load_high_in  ? wdata_in[NIB_W-1:0] :
                       stepped[PTR_W-1:BYTE_W];
    assign low_next  = load_low_in ? wdata_in : stepped[BYTE_W-1:0];

    // High part clears on every kind of reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            high_reg <= HIGH_RESET;
        end else begin
            high_reg <= high_next;
        end
    end

    // Low byte has no reset: undefined at power-up, kept otherwise
    always_ff @(posedge clk_in) begin
        low_reg <= low_next;
    end

endmodule : idau_pointer

//--- verification/idau_proc_model.sv
// Processor-side model: bus master and non-power-up reset sources
module idau_proc_model (
    input  wire logic        clk_in,
    input  wire logic        wait_in,
    output logic      [7:0]  addr_out,
    output logic             rd_out,
    output logic             wr_out,
    output logic      [31:0] wdata_out,
    output logic      [3:0]  be_out,
    output logic             pin_n_out,
    output logic             wdt_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr_out = 8'h00;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 32'h0;
        be_out = 4'h0;
        pin_n_out = 1'b1;
        wdt_out = 1'b0;
    end

    // =================================================================
    // One bus access, held until waitrequest is seen low
    task access(input logic w, input logic [7:0] a, input logic [31:0] d,
                input logic [3:0] e);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= !w;
        wr_out <= w;
        wdata_out <= d;
        be_out <= e;
        // Sampled before this edge's updates, so low means answered here
        do begin
            @(posedge clk_in);
        end while (wait_in !== 1'b0);
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        // Stale values must not look valid once released
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask : access

    // =================================================================
    // Non-power-up reset sources
    task wdt_pulse();
        @(posedge clk_in);
        wdt_out <= 1'b1;
        @(posedge clk_in);
        wdt_out <= 1'b0;
    endtask : wdt_pulse

    task pin_pulse();
        @(posedge clk_in);
        pin_n_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        pin_n_out <= 1'b1;
        repeat (4) @(posedge clk_in);
    endtask : pin_pulse
endmodule : idau_proc_model

//--- verification/idau_top_tb.sv
// Self-checking bench of the indirect data addressing unit
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    fail_count++; $display("ERROR %0t read %h expected %h", $time, a, e); \
    end end
module idau_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import idau_pkg::*;

    logic              clk;
    logic              rst;
    logic              pin_n;
    logic              wdt;
    logic [ADDR_W-1:0] addr;
    logic              rd_en;
    logic              wr_en;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0]   be;
    logic [DATA_W-1:0] rdata;
    logic              waitreq;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] exp_d;
    logic [31:0]       seed;
    logic [PTR_W-1:0]  ptr;
    logic [7:0]        acc;
    logic [7:0]        d0;
    logic [7:0]        d1;
    logic [7:0]        d2;
    logic [7:0]        b;
    int                fail_count = 0;
    int                samples_checked = 0;
    int                cycles = 0;

    idau_top u_dut (
        .CORE_CLK_IN(clk), .RST_IN(rst), .EXTERNAL_RESET_PIN_N_IN(pin_n),
        .WATCHDOG_RESET_IN(wdt), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd_en),
        .AVS_WRITE_IN(wr_en), .AVS_WRITEDATA_IN(wdata),
        .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(waitreq)
    );

    idau_proc_model u_proc (
        .clk_in(clk), .wait_in(waitreq), .addr_out(addr), .rd_out(rd_en),
        .wr_out(wr_en), .wdata_out(wdata), .be_out(be), .pin_n_out(pin_n),
        .wdt_out(wdt)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // =================================================================
    // Helpers
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task wr(input logic [7:0] a, input logic [7:0] d);
        u_proc.access(1'b1, a, {24'h0, d}, 4'hF);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        u_proc.access(1'b0, a, 32'h0, 4'hF);
    endtask : rd

    task setp(input logic [PTR_W-1:0] v);
        wr(b + 8'h14, {4'h0, v[11:8]});
        wr(b + 8'h18, v[7:0]);
    endtask : setp

    task test_done();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // =================================================================
    // Result watcher and hang guard
    always @(negedge clk) begin
        if (rd_en === 1'b1 && waitreq === 1'b0) begin
            exp_d = exp_q.pop_front();
            `CHK(rdata, exp_d)
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            test_done();
        end
    end

    // =================================================================
    // Main sequence
    initial begin
        seed = 32'h9ABF6789;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int p = 0; p < 3; p++) rd(8'(p * 32 + 20), 8'h00);
        rd(8'h64, 8'h00);
        rd(8'h1C, 8'h00);
        rd(8'h80, 8'h00);
        rd(8'h65, 8'h00);
        $display("reset test done");
        for (int p = 0; p < 3; p++) begin
            b = 8'(p * 32);
            ptr = PTR_W'(rnd());
            // Pointer 0 starts at a low-byte edge to force the carry
            if (p == 0) ptr[7:0] = 8'hFF;
            d0 = 8'(rnd());
            d1 = 8'(rnd());
            d2 = 8'(rnd());
            acc = 8'(rnd());
            setp(ptr);
            wr(b + 8'h04, d0);
            rd(b + 8'h18, 8'(ptr + 12'h1));
            rd(b + 8'h14, {4'h0, 4'((ptr + 12'h1) >> 8)});
            wr(b + 8'h0C, d1);
            rd(b + 8'h08, d1);
            rd(b + 8'h0C, d1);
            rd(b, d1);
            rd(b + 8'h18, 8'(ptr + 12'h2));
            wr(8'h60, acc);
            wr(b + 8'h10, d2);
            rd(b + 8'h10, d2);
            rd(b + 8'h18, 8'(ptr + 12'h2));
            setp(ptr + 12'h2 + {4'h0, acc});
            rd(b, d2);
            setp(ptr);
            rd(b, d0);
            // Byte lane off: no write, but the pointer still steps
            u_proc.access(1'b1, b + 8'h08, {24'h0, ~d0}, 4'h0);
            rd(b + 8'h0C, d0);
            $display("pointer %0d test done", p);
        end
        wr(8'h64, 8'h0A);
        wr(8'h54, 8'h0F);
        rd(8'h64, 8'h0A);
        u_proc.wdt_pulse();
        rd(8'h54, 8'h00);
        rd(8'h58, ptr[7:0]);
        rd(8'h60, acc);
        rd(8'h64, 8'h00);
        wr(8'h34, 8'h0F);
        rd(8'h34, 8'h0F);
        u_proc.pin_pulse();
        rd(8'h34, 8'h00);
        rd(8'h60, acc);
        $display("other reset test done");
        test_done();
    end
endmodule : idau_top_tb
